// file: rtl/reset_and_boot_vector_control.sv
// Functional notes
// - Reset halts core, resets registers except power-on bits
// - Reset disables interrupts and timers
// - RAM contents survive every reset
// - Port latches one, open-drain; pull-ups always on
// - Supply or power-on reset drives pin low
// - Exit: clear counter, internal clock, watchdog on
// - Eight sources each request reset
// - Bootloader present only when signature equals 0xa5
// - Start at boot vector or reset vector
// - Idle wake-up resumes within 2 to 3 cycles
`timescale 1ns/1ps
`default_nettype none
module reset_and_boot_vector_control
	import rst_boot_pkg::*;
#(
	parameter logic [15:0] BOOT_VECTOR = 16'h3e00,
	parameter int RESET_HOLD_CYC = 4
)
(
	// Clock, power-on reset, clock enable
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire logic I_CE,
	// Asynchronous reset sources from pins and analog monitors
	input wire logic I_EXT_RESET_PIN_N,
	input wire logic I_CMP_RESET,
	input wire logic I_SUPPLY_MON_RESET,
	// Synchronous reset sources
	input wire logic I_SW_RESET,
	input wire logic I_WDT_RESET,
	input wire logic I_MISSING_CLK_RESET,
	input wire logic I_FLASH_ERR_RESET,
	// Flash signature byte and idle control
	input wire logic [7:0] I_BOOT_SIG,
	input wire logic I_IDLE_REQ,
	input wire logic I_WAKE,
	// Core and module control
	output logic O_CORE_HALT,
	output logic O_MODULE_RESET,
	output logic O_POR_ONLY_RESET,
	output logic O_IRQ_DISABLE,
	output logic O_TIMER_DISABLE,
	output logic O_RAM_WRITE_BLOCK,
	// Port defaults
	output logic O_PORT_LATCH_SET,
	output logic O_PORT_OPEN_DRAIN,
	output logic O_WEAK_PULLUP_EN,
	// External reset pin driver
	output logic O_EXT_RESET_PIN_N_O,
	output logic O_EXT_RESET_PIN_N_OE,
	// Start-up values
	output logic [15:0] O_PROGRAM_COUNTER,
	output logic O_EXIT_DEFAULTS,
	output logic O_BOOT_SELECTED,
	output logic O_IDLE,
	output logic [7:0] O_RESET_CAUSE
);
	// ************************************************************
	// Input synchronisers
	// ************************************************************
	logic [2:0] meta_r; // First stage, read only by second stage
	logic [2:0] sync_r; // Pin, comparator, supply monitor
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			meta_r <= 3'h1;
			sync_r <= 3'h1;
		end
		else if (I_CE)
		begin
			meta_r <= {I_SUPPLY_MON_RESET, I_CMP_RESET, I_EXT_RESET_PIN_N};
			sync_r <= meta_r;
		end
	end

	// ************************************************************
	// Sequencer state and output registers
	// ************************************************************
	seq_state_type state_r, state_nxt; // Sequencer state
	logic [7:0] hold_r, hold_nxt; // Release delay counter
	logic [1:0] wake_r, wake_nxt; // Idle wake-up countdown
	logic waking_r, waking_nxt; // Wake event seen in idle
	logic [7:0] cause_r, cause_nxt; // Sticky causes of this episode
	logic drive_r, drive_nxt; // Pulling the reset pin low
	logic [15:0] pc_r, pc_nxt; // Start address
	logic exit_r, exit_nxt; // One-cycle launch pulse
	logic boot_r, boot_nxt; // Bootloader chosen at launch
	logic idle_r, idle_nxt; // Core idling
	logic [7:0] req; // Reset requests this cycle
	logic any_req;

	// Signature check used at launch
	function automatic logic boot_present(input logic [7:0] sig);
		boot_present = (sig == BOOT_SIG_PRESENT);
	endfunction

	// Gather sources; our own pin drive must not re-trigger reset
	always_comb
	begin
		req = '0;
		req[SRC_PIN] = ~sync_r[0] & ~drive_r;
		req[SRC_CMP] = sync_r[1];
		req[SRC_SW] = I_SW_RESET;
		req[SRC_SUPPLY] = sync_r[2];
		req[SRC_WDT] = I_WDT_RESET;
		req[SRC_MISS_CLK] = I_MISSING_CLK_RESET;
		req[SRC_FLASH] = I_FLASH_ERR_RESET;
		any_req = |req;
	end

	// Next-state logic
	always_comb
	begin
		state_nxt = state_r;
		hold_nxt = hold_r;
		wake_nxt = wake_r;
		waking_nxt = waking_r;
		cause_nxt = cause_r;
		drive_nxt = drive_r;
		pc_nxt = pc_r;
		exit_nxt = 1'b0;
		boot_nxt = boot_r;
		case (state_r)
			// Stay while any request stands, then count off the hold
			ST_RESET:
			begin
				cause_nxt = cause_r | req;
				drive_nxt = drive_r | req[SRC_SUPPLY];
				pc_nxt = RESET_VECTOR;
				if (any_req)
					hold_nxt = 8'(RESET_HOLD_CYC - 1);
				else if (hold_r != 8'h00)
					hold_nxt = hold_r - 8'h01;
				else
				begin
					state_nxt = ST_LAUNCH;
					drive_nxt = 1'b0;
				end
			end
			// Pick the start address and pulse the defaults
			ST_LAUNCH:
			begin
				boot_nxt = boot_present(I_BOOT_SIG);
				pc_nxt = boot_present(I_BOOT_SIG) ? BOOT_VECTOR : RESET_VECTOR;
				exit_nxt = 1'b1;
				state_nxt = ST_RUN;
			end
			// Normal execution
			ST_RUN:
			begin
				if (I_IDLE_REQ)
					state_nxt = ST_IDLE;
			end
			// Idle: wake after a fixed three-cycle latency
			ST_IDLE:
			begin
				if (waking_r)
				begin
					if (wake_r != 2'h0)
						wake_nxt = wake_r - 2'h1;
					else
					begin
						waking_nxt = 1'b0;
						state_nxt = ST_RUN;
					end
				end
				else if (I_WAKE)
				begin
					waking_nxt = 1'b1;
					wake_nxt = 2'(IDLE_WAKE_MIN_CYC - 1);
				end
			end
			default:
				state_nxt = ST_RESET;
		endcase
		// Any request outside reset starts a fresh episode
		if (state_r != ST_RESET && any_req)
		begin
			state_nxt = ST_RESET;
			cause_nxt = req;
			drive_nxt = req[SRC_SUPPLY];
			hold_nxt = 8'(RESET_HOLD_CYC - 1);
			waking_nxt = 1'b0;
			exit_nxt = 1'b0;
		end
		idle_nxt = (state_nxt == ST_IDLE);
	end

	// Register stage; power-on loads constants only
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			state_r <= ST_RESET;
			hold_r <= 8'(RESET_HOLD_CYC - 1);
			wake_r <= 2'h0;
			waking_r <= 1'b0;
			cause_r <= CAUSE_POR_VALUE;
			drive_r <= 1'b1;
			pc_r <= RESET_VECTOR;
			exit_r <= 1'b0;
			boot_r <= 1'b0;
			idle_r <= 1'b0;
		end
		else if (I_CE)
		begin
			state_r <= state_nxt;
			hold_r <= hold_nxt;
			wake_r <= wake_nxt;
			waking_r <= waking_nxt;
			cause_r <= cause_nxt;
			drive_r <= drive_nxt;
			pc_r <= pc_nxt;
			exit_r <= exit_nxt;
			boot_r <= boot_nxt;
			idle_r <= idle_nxt;
		end
	end

	// ************************************************************
	// Output drive
	// ************************************************************
	// Reset-state controls follow the registered state; no combinational path
	logic in_reset;
	assign in_reset = (state_r == ST_RESET);
	logic halt_r, halt_nxt;
	logic por_r, por_nxt;
	always_comb
	begin
		halt_nxt = (state_nxt == ST_RESET);
		por_nxt = (state_nxt == ST_RESET) & cause_nxt[SRC_POR];
	end
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			halt_r <= 1'b1;
			por_r <= 1'b1;
		end
		else if (I_CE)
		begin
			halt_r <= halt_nxt;
			por_r <= por_nxt;
		end
	end
	assign O_CORE_HALT = halt_r;
	assign O_MODULE_RESET = halt_r;
	assign O_POR_ONLY_RESET = por_r;
	assign O_IRQ_DISABLE = halt_r;
	assign O_TIMER_DISABLE = halt_r;
	// RAM has no reset path; only writes are blocked while halted
	assign O_RAM_WRITE_BLOCK = halt_r;
	assign O_PORT_LATCH_SET = halt_r;
	assign O_PORT_OPEN_DRAIN = halt_r;
	assign O_WEAK_PULLUP_EN = 1'b1;
	assign O_EXT_RESET_PIN_N_O = 1'b0;
	assign O_EXT_RESET_PIN_N_OE = drive_r;
	assign O_PROGRAM_COUNTER = pc_r;
	assign O_EXIT_DEFAULTS = exit_r;
	assign O_BOOT_SELECTED = boot_r;
	assign O_IDLE = idle_r;
	assign O_RESET_CAUSE = cause_r;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	property p_halt_on_req;
		I_CE && any_req |=> O_CORE_HALT && O_IRQ_DISABLE;
	endproperty
	a_halt_on_req: assert property (p_halt_on_req) else $error("core not halted on reset request");
	property p_timers_off;
		O_CORE_HALT |-> O_TIMER_DISABLE && O_IRQ_DISABLE;
	endproperty
	a_timers_off: assert property (p_timers_off) else $error("timers or interrupts live in reset");
	property p_ram_block;
		O_CORE_HALT |-> O_RAM_WRITE_BLOCK;
	endproperty
	a_ram_block: assert property (p_ram_block) else $error("ram writable during reset");
	property p_port_state;
		O_CORE_HALT |-> O_PORT_LATCH_SET && O_PORT_OPEN_DRAIN && O_WEAK_PULLUP_EN;
	endproperty
	a_port_state: assert property (p_port_state) else $error("ports not in reset state");
	property p_pin_drive;
		I_CE && in_reset && sync_r[2] |=> O_EXT_RESET_PIN_N_OE;
	endproperty
	a_pin_drive: assert property (p_pin_drive) else $error("supply reset not driven on pin");
	property p_pin_release;
		!O_CORE_HALT |-> !O_EXT_RESET_PIN_N_OE;
	endproperty
	a_pin_release: assert property (p_pin_release) else $error("pin driven outside reset");
	property p_exit;
		I_CE && $fell(O_CORE_HALT) && !any_req |=> O_EXIT_DEFAULTS;
	endproperty
	a_exit: assert property (p_exit) else $error("launch pulse missing");
	property p_vector;
		O_EXIT_DEFAULTS |-> O_PROGRAM_COUNTER == (O_BOOT_SELECTED ? BOOT_VECTOR : RESET_VECTOR);
	endproperty
	a_vector: assert property (p_vector) else $error("wrong start vector");
	property p_sig;
		I_CE && state_r == ST_LAUNCH && !any_req |=> O_BOOT_SELECTED == ($past(I_BOOT_SIG) == BOOT_SIG_PRESENT);
	endproperty
	a_sig: assert property (p_sig) else $error("signature decode wrong");
	property p_wake;
		I_CE && state_r == ST_IDLE && !waking_r && I_WAKE && !any_req ##1 I_CE [*2] |=> !O_IDLE;
	endproperty
	a_wake: assert property (p_wake) else $error("idle wake latency wrong");
	property p_release;
		I_CE && in_reset && !any_req && hold_r == 8'h00 |=> !O_CORE_HALT && !O_EXT_RESET_PIN_N_OE;
	endproperty
	a_release: assert property (p_release) else $error("reset outputs split");
	c_boot: cover property (O_EXIT_DEFAULTS && O_BOOT_SELECTED);
	c_plain: cover property (O_EXIT_DEFAULTS && !O_BOOT_SELECTED);
	c_wake: cover property ($fell(O_IDLE));
	c_wdt: cover property (O_CORE_HALT && O_RESET_CAUSE[SRC_WDT]);
endmodule
`default_nettype wire

// file: rtl/rst_boot_pkg.sv
// ************************************************************
// Shared constants for the reset and boot vector controller
// ************************************************************
package rst_boot_pkg;
	// Reset source bit positions in the cause vector
	localparam int SRC_POR = 0;
	localparam int SRC_PIN = 1;
	localparam int SRC_CMP = 2;
	localparam int SRC_SW = 3;
	localparam int SRC_SUPPLY = 4;
	localparam int SRC_WDT = 5;
	localparam int SRC_MISS_CLK = 6;
	localparam int SRC_FLASH = 7;
	localparam int NUM_SRC = 8;
	// Cause vector after power-on
	localparam logic [7:0] CAUSE_POR_VALUE = 8'h01;
	// Vectors and signature
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	localparam logic [7:0] BOOT_SIG_PRESENT = 8'ha5;
	// Clock period and idle wake-up window in system clock cycles
	localparam int CLK_PERIOD_NS = 100;
	localparam int IDLE_WAKE_MIN_CYC = 2;
	localparam int IDLE_WAKE_MAX_CYC = 3;
	// Sequencer states, Gray coded along reset, launch, run, idle
	typedef enum logic [1:0]
	{
		ST_RESET = 2'b00,
		ST_LAUNCH = 2'b01,
		ST_RUN = 2'b11,
		ST_IDLE = 2'b10
	} seq_state_type;
endpackage

// file: sim/boot_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Flash stand-in holding the boot signature byte
// ************************************************************
module boot_flash_model
#(
	parameter int LOCK_ADDR = 16383
)
(
	// Clock and write port
	input wire logic i_clk,
	input wire logic i_we,
	input wire logic [7:0] i_wdata,
	// Signature byte to the controller
	output logic [7:0] o_sig
);
	// Only the top bytes matter here, rest left uninitialised
	logic [7:0] mem [0:LOCK_ADDR];
	// Erased flash reads all ones
	initial
	begin
		mem[LOCK_ADDR-1] = 8'hff;
		mem[LOCK_ADDR] = 8'hff;
	end
	// Program the byte below the lock byte
	always @(posedge i_clk)
	begin
		if (i_we)
		begin
			mem[LOCK_ADDR-1] <= i_wdata;
		end
	end
	// Signature sits one below the lock byte
	assign o_sig = mem[LOCK_ADDR-1];
endmodule
`default_nettype wire

// file: sim/reset_and_boot_vector_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module reset_and_boot_vector_control_tb;
	import rst_boot_pkg::*;
	localparam logic [15:0] BV = 16'h3e00;
	logic clk, rst_n, we, idle_req, wake;
	logic [7:0] src, wd, sig, cause;
	logic halt, mres, por, irq, tmr, ram, lat, od, pu, pin_o, oe, ex, boot, idl;
	logic [15:0] pc;
	logic [24:0] exp_q [$];
	int fails, checked;
	// ************************************************************
	// Clock, design and flash model
	// ************************************************************
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	reset_and_boot_vector_control #(.BOOT_VECTOR(BV), .RESET_HOLD_CYC(4)) u_reset_and_boot_vector_control (
		.I_CLK(clk), .I_RST_N(rst_n), .I_CE(1'b1), .I_EXT_RESET_PIN_N(~src[1]),
		.I_CMP_RESET(src[2]), .I_SUPPLY_MON_RESET(src[4]), .I_SW_RESET(src[3]),
		.I_WDT_RESET(src[5]), .I_MISSING_CLK_RESET(src[6]), .I_FLASH_ERR_RESET(src[7]),
		.I_BOOT_SIG(sig), .I_IDLE_REQ(idle_req), .I_WAKE(wake), .O_CORE_HALT(halt),
		.O_MODULE_RESET(mres), .O_POR_ONLY_RESET(por), .O_IRQ_DISABLE(irq), .O_TIMER_DISABLE(tmr),
		.O_RAM_WRITE_BLOCK(ram), .O_PORT_LATCH_SET(lat), .O_PORT_OPEN_DRAIN(od),
		.O_WEAK_PULLUP_EN(pu), .O_EXT_RESET_PIN_N_O(pin_o), .O_EXT_RESET_PIN_N_OE(oe),
		.O_PROGRAM_COUNTER(pc), .O_EXIT_DEFAULTS(ex), .O_BOOT_SELECTED(boot), .O_IDLE(idl),
		.O_RESET_CAUSE(cause));
	boot_flash_model u_boot_flash_model (.i_clk(clk), .i_we(we), .i_wdata(wd), .o_sig(sig));
	// ************************************************************
	// Compare, verdict and checking tasks
	// ************************************************************
	// Wide enough for the longest packed group of outputs, so no bit is cut
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("fails=%0d checked=%0d", fails, checked);
		if (fails == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Expected exit: boot flag, cause, start vector
	function automatic logic [24:0] expv(input logic [7:0] s, input logic [7:0] c);
		return {s == 8'ha5, c, (s == 8'ha5) ? BV : RESET_VECTOR};
	endfunction
	// Program signature, fire one source, follow the reset through
	task automatic fire(input int i, input logic [7:0] s);
		int n;
		@(negedge clk);
		we = 1'b1;
		wd = s;
		@(negedge clk);
		we = 1'b0;
		src = 8'h01 << i;
		exp_q.push_back(expv(s, 8'h01 << i));
		repeat (4) @(negedge clk);
		src = 8'h00;
		@(negedge clk);
		// Halt, module reset, port defaults, pin drive only for supply
		chk({halt, mres, irq, tmr, ram, lat, od, pu, por, oe, pc}, {8'hff, 1'b0, i == 4, 16'h0});
		n = 0;
		while (ex !== 1'b1 && n < 30)
		begin
			@(negedge clk);
			n++;
		end
		chk(n < 30, 1'b1);
		@(negedge clk);
	endtask
	// ************************************************************
	// Monitor: each exit pulse consumes the oldest expectation
	// ************************************************************
	always @(negedge clk)
	begin
		if (ex === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk(25'h0, 25'h1ffffff);
			else
				chk({boot, cause, pc}, exp_q.pop_front());
		end
	end
	// Watchdog on the whole run
	initial
	begin
		#(100 * 4000);
		fails++;
		complete_run();
	end
	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		logic [7:0] s;
		fails = 0;
		checked = 0;
		rst_n = 1'b0;
		src = 8'h00;
		we = 1'b0;
		wd = 8'h00;
		idle_req = 1'b0;
		wake = 1'b0;
		s = $urandom(32'h89f9);
		repeat (4) @(negedge clk);
		// Power-on state: everything held, pin pulled low
		chk({halt, mres, irq, tmr, ram, lat, od, pu, por, oe, pin_o, pc}, {10'h3ff, 1'b0, 16'h0});
		exp_q.push_back(expv(8'hff, CAUSE_POR_VALUE));
		@(negedge clk);
		rst_n = 1'b1;
		repeat (12) @(negedge clk);
		// Every source except power-on, twice, signature picked at random as 0xa5 or a random byte
		for (int k = 0; k < 2; k++)
		begin
			for (int i = 1; i < NUM_SRC; i++)
			begin
				s = ($urandom % 2) ? 8'ha5 : 8'($urandom);
				fire(i, s);
			end
		end
		// Idle then wake: exactly three cycles to resume
		idle_req = 1'b1;
		@(negedge clk);
		idle_req = 1'b0;
		chk(idl, 1'b1);
		wake = 1'b1;
		@(negedge clk);
		wake = 1'b0;
		chk(idl, 1'b1);
		@(negedge clk);
		chk(idl, 1'b1);
		@(negedge clk);
		chk(idl, 1'b0);
		chk(exp_q.size(), 25'h0);
		complete_run();
	end
endmodule
`default_nettype wire
